/* core/lfm_pkg.sv */
// package for the led fault and thermal monitor
package lfm_pkg;
    localparam int NSW = 12;
    localparam int DUTY_W = 12;
    localparam int REG_W = 13;

    localparam logic [7:0] ADDR_MASK_CFG = 8'h0C;
    localparam logic [7:0] ADDR_GEN_STAT = 8'h10;
    localparam logic [7:0] ADDR_SHORT_STAT = 8'h12;
    localparam logic [7:0] ADDR_OPEN_STAT = 8'h13;
    localparam logic [7:0] ADDR_TRACE_STAT = 8'h14;
    localparam logic [7:0] ADDR_LOW_DUTY = 8'h16;

    // fault_mask_config fields
    localparam int MSK_SHORT_BIT = 0;
    localparam int MSK_TRACE_BIT = 1;
    localparam int MSK_OPEN_BIT = 2;
    localparam int SHDN_ACT_BIT = 3;
    localparam int MSK_THERM_BIT = 4;
    // general_status fields
    localparam int GS_WARN_BIT = 0;
    localparam int GS_SHDN_BIT = 1;
    localparam int GS_GRADE_BIT = 2;
    localparam int GS_SERIAL_BIT = 3;

    localparam logic [REG_W-1:0] MASK_CFG_RST = 13'h0000;
    localparam logic [DUTY_W-1:0] LOW_DUTY_RST = 12'h000;

    typedef logic [NSW-1:0][DUTY_W-1:0] lfm_duty_t;

    typedef struct packed {
        logic [NSW-1:0] short_cmp;
        logic [NSW-1:0] low_cur;
        logic [NSW-1:0] open_cmp;
        logic warn_hot;
        logic shdn_hot;
        logic grade_err;
    } lfm_sense_t;
endpackage

/* core/lfm_monitor.sv */
// led fault and thermal supervision for a 12-switch bypass matrix
// Function
// - an open switch with drain-source below short threshold sets its short status bit
// - short comparator is sampled only at the end of each led on-pulse
// - short fault leaves switch running; pulls fault pin unless short mask set
// - duty below low-duty threshold suppresses short fault and clears its status
// - too little current through a closed switch sets its open-trace status bit
// - open-trace fault leaves switch running; pulls fault pin unless masked
// - open-trace comparator sampled just before the switch turns from on to off
// - above warning temperature set warning flag and fault pin, switches untouched
// - warning flag clears on write-one only while below warning temperature
// - after a warning, fault pin holds until cool and warning flag cleared
// - above shutdown temperature set shutdown flag, fault pin, force all switches
// - register access keeps working; forced state held until hysteresis recovery
// - after shutdown recovery switches resume their programmed state
// - after shutdown, fault pin holds until cool and both flags cleared
// - open-led fault sets open status, keeps switch closed until reset except while shutdown forces the switches, pulls pin
// - fault pin asserts on open, short, thermal, grading or serial errors
`timescale 1ns/1ps
module lfm_monitor (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire lfm_pkg::lfm_sense_t i_sense,
    input wire logic [lfm_pkg::NSW-1:0] i_sw_open,
    input wire lfm_pkg::lfm_duty_t i_duty,
    input wire logic i_serial_err,
    input wire logic [7:0] i_reg_addr,
    input wire logic [lfm_pkg::REG_W-1:0] i_reg_wdata,
    input wire logic i_reg_we,
    input wire logic i_reg_re,
    output logic [lfm_pkg::REG_W-1:0] o_reg_rdata,
    output logic [lfm_pkg::NSW-1:0] o_sw_open,
    output logic o_fault_n
);
    localparam int N = lfm_pkg::NSW;

    lfm_pkg::lfm_sense_t sense_meta_reg;
    lfm_pkg::lfm_sense_t sense_reg;
    logic [N-1:0] prev_open_reg;
    logic [lfm_pkg::REG_W-1:0] mask_reg;
    logic [lfm_pkg::DUTY_W-1:0] low_duty_reg;
    logic [N-1:0] short_reg;
    logic [N-1:0] trace_reg;
    logic [N-1:0] open_reg;
    logic warn_reg;
    logic shdn_reg;
    logic shdn_active_reg;

    logic [N-1:0] short_evt;
    logic [N-1:0] trace_evt;
    logic [N-1:0] low_duty;
    logic [N-1:0] short_next;
    logic [N-1:0] trace_next;
    logic [N-1:0] sw_next;
    logic gen_wr;
    logic fault_any;

    // two-stage synchroniser for all analogue comparators
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sense_meta_reg <= '0;
            sense_reg <= '0;
        end else begin
            sense_meta_reg <= i_sense;
            sense_reg <= sense_meta_reg;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_open_reg <= '0;
        end else begin
            prev_open_reg <= i_sw_open;
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            low_duty[i] = i_duty[i] < low_duty_reg;
        end
        short_evt = prev_open_reg & ~i_sw_open;
        trace_evt = ~prev_open_reg & i_sw_open;
        short_next = short_reg;
        trace_next = trace_reg;
        for (int i = 0; i < N; i++) begin
            if (short_evt[i]) begin
                short_next[i] = sense_reg.short_cmp[i];
            end
            if (low_duty[i]) begin
                short_next[i] = 1'b0;
            end
            if (trace_evt[i]) begin
                trace_next[i] = sense_reg.low_cur[i];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            short_reg <= '0;
            trace_reg <= '0;
        end else begin
            short_reg <= short_next;
            trace_reg <= trace_next;
        end
    end

    // open-led latch stays until reset
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            open_reg <= '0;
        end else begin
            open_reg <= open_reg | (prev_open_reg & sense_reg.open_cmp);
        end
    end

    // configuration registers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_reg <= lfm_pkg::MASK_CFG_RST;
            low_duty_reg <= lfm_pkg::LOW_DUTY_RST;
        end else if (i_reg_we) begin
            if (i_reg_addr == lfm_pkg::ADDR_MASK_CFG) begin
                mask_reg <= i_reg_wdata;
            end
            if (i_reg_addr == lfm_pkg::ADDR_LOW_DUTY) begin
                low_duty_reg <= i_reg_wdata[lfm_pkg::DUTY_W-1:0];
            end
        end
    end

    assign gen_wr = i_reg_we && (i_reg_addr == lfm_pkg::ADDR_GEN_STAT);

    // thermal flags, set wins over write-one-to-clear
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            warn_reg <= 1'b0;
            shdn_reg <= 1'b0;
        end else begin
            if (sense_reg.warn_hot) begin
                warn_reg <= 1'b1;
            end else if (gen_wr && i_reg_wdata[lfm_pkg::GS_WARN_BIT]) begin
                warn_reg <= 1'b0;
            end
            if (sense_reg.shdn_hot) begin
                shdn_reg <= 1'b1;
            end else if (gen_wr && i_reg_wdata[lfm_pkg::GS_SHDN_BIT]
                         && !sense_reg.warn_hot) begin
                shdn_reg <= 1'b0;
            end
        end
    end

    // shutdown comparator carries the hysteresis
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shdn_active_reg <= 1'b0;
        end else begin
            shdn_active_reg <= sense_reg.shdn_hot;
        end
    end

    always_comb begin
        if (shdn_active_reg) begin
            sw_next = {N{~mask_reg[lfm_pkg::SHDN_ACT_BIT]}};
        end else begin
            sw_next = i_sw_open & ~open_reg;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sw_open <= '0;
        end else begin
            o_sw_open <= sw_next;
        end
    end

    always_comb begin
        fault_any = 1'b0;
        if (|short_reg && !mask_reg[lfm_pkg::MSK_SHORT_BIT]) begin
            fault_any = 1'b1;
        end
        if (|trace_reg && !mask_reg[lfm_pkg::MSK_TRACE_BIT]) begin
            fault_any = 1'b1;
        end
        if (|open_reg && !mask_reg[lfm_pkg::MSK_OPEN_BIT]) begin
            fault_any = 1'b1;
        end
        if ((warn_reg || shdn_reg) && !mask_reg[lfm_pkg::MSK_THERM_BIT]) begin
            fault_any = 1'b1;
        end
        if (sense_reg.grade_err || i_serial_err) begin
            fault_any = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fault_n <= 1'b1;
        end else begin
            o_fault_n <= !fault_any;
        end
    end

    // register readback, unmapped addresses read zero
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= '0;
        end else if (i_reg_re) begin
            case (i_reg_addr)
                lfm_pkg::ADDR_MASK_CFG: o_reg_rdata <= mask_reg;
                lfm_pkg::ADDR_GEN_STAT: begin
                    o_reg_rdata <= '0;
                    o_reg_rdata[lfm_pkg::GS_WARN_BIT] <= warn_reg;
                    o_reg_rdata[lfm_pkg::GS_SHDN_BIT] <= shdn_reg;
                    o_reg_rdata[lfm_pkg::GS_GRADE_BIT] <= sense_reg.grade_err;
                    o_reg_rdata[lfm_pkg::GS_SERIAL_BIT] <= i_serial_err;
                end
                lfm_pkg::ADDR_SHORT_STAT: o_reg_rdata <= {1'b0, short_reg};
                lfm_pkg::ADDR_OPEN_STAT: o_reg_rdata <= {1'b0, open_reg};
                lfm_pkg::ADDR_TRACE_STAT: o_reg_rdata <= {1'b0, trace_reg};
                lfm_pkg::ADDR_LOW_DUTY: o_reg_rdata <= {1'b0, low_duty_reg};
                default: o_reg_rdata <= '0;
            endcase
        end
    end

    // checks
    a_short_sample: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (short_evt[0] && sense_reg.short_cmp[0] && !low_duty[0]) |=> short_reg[0])
        else $error("short fault not latched at pulse end");
    a_short_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!short_evt[0] && !low_duty[0]) |=> short_reg[0] == $past(short_reg[0]))
        else $error("short status changed outside pulse end");
    a_low_duty: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        low_duty[3] |=> !short_reg[3])
        else $error("short status set under low duty");
    a_trace_sample: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (trace_evt[11] && sense_reg.low_cur[11]) |=> trace_reg[11])
        else $error("open trace not latched at turn-off edge");
    a_trace_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !trace_evt[1] |=> $stable(trace_reg[1]))
        else $error("open trace status changed off edge");
    a_warn_stick: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (warn_reg && sense_reg.warn_hot) |=> warn_reg)
        else $error("warning flag lost while hot");
    a_shdn_force: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        shdn_active_reg |=> o_sw_open == {N{~$past(mask_reg[lfm_pkg::SHDN_ACT_BIT])}})
        else $error("switches not forced during shutdown");
    a_resume_prog: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !shdn_active_reg |=> o_sw_open == ($past(i_sw_open) & ~$past(open_reg)))
        else $error("switches not following program");
    a_open_lock: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        open_reg[5] && !shdn_active_reg |=> !o_sw_open[5] ##1 open_reg[5])
        else $error("open led switch not held closed");
    a_fault_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (warn_reg && !mask_reg[lfm_pkg::MSK_THERM_BIT]) |=> !o_fault_n)
        else $error("fault pin not asserted for thermal flag");
    a_fault_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (short_reg == '0 && trace_reg == '0 && open_reg == '0 && !warn_reg && !shdn_reg
         && !sense_reg.grade_err && !i_serial_err) |=> o_fault_n)
        else $error("fault pin asserted with no fault");

    // fault sensing and pin
    a_short_masked: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (|short_reg && !mask_reg[lfm_pkg::MSK_SHORT_BIT]) |=> !o_fault_n)
        else $error("fault pin not asserted for short fault");
    a_short_keep: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!shdn_active_reg && !open_reg[0]) |=> o_sw_open[0] == $past(i_sw_open[0]))
        else $error("short fault changed switch state");
    a_trace_masked: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (|trace_reg && !mask_reg[lfm_pkg::MSK_TRACE_BIT]) |=> !o_fault_n)
        else $error("fault pin not asserted for open trace");
    a_trace_keep: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!shdn_active_reg && !open_reg[11]) |=> o_sw_open[11] == $past(i_sw_open[11]))
        else $error("open trace changed switch state");
    a_low_duty_one: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        low_duty[1] |=> !short_reg[1])
        else $error("short status set under low duty");
    a_open_detect: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (prev_open_reg[5] && sense_reg.open_cmp[5]) |=> open_reg[5])
        else $error("open led fault not latched");
    a_open_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        open_reg[5] |=> open_reg[5])
        else $error("open led status lost before reset");
    a_open_masked: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (|open_reg && !mask_reg[lfm_pkg::MSK_OPEN_BIT]) |=> !o_fault_n)
        else $error("fault pin not asserted for open led");
    a_grade_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        sense_reg.grade_err |=> !o_fault_n)
        else $error("fault pin not asserted for grading error");
    a_serial_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_serial_err |=> !o_fault_n)
        else $error("fault pin not asserted for serial error");

    // thermal flags and forcing
    a_warn_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        sense_reg.warn_hot |=> warn_reg)
        else $error("warning flag not set while hot");
    a_warn_keep_sw: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (sense_reg.warn_hot && !shdn_active_reg)
        |=> o_sw_open[9] == ($past(i_sw_open[9]) & ~$past(open_reg[9])))
        else $error("warning changed switch state");
    a_warn_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (gen_wr && i_reg_wdata[lfm_pkg::GS_WARN_BIT] && !sense_reg.warn_hot) |=> !warn_reg)
        else $error("warning flag not cleared by write one");
    a_shdn_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        sense_reg.shdn_hot |=> shdn_reg)
        else $error("shutdown flag not set while hot");
    a_shdn_entry: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        sense_reg.shdn_hot |=> shdn_active_reg)
        else $error("shutdown forcing not entered");
    a_shdn_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (shdn_reg && sense_reg.warn_hot) |=> shdn_reg)
        else $error("shutdown flag cleared while hot");
    a_shdn_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (shdn_reg && !mask_reg[lfm_pkg::MSK_THERM_BIT]) |=> !o_fault_n)
        else $error("fault pin not asserted for shutdown flag");

    // register access
    a_mask_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_reg_we && i_reg_addr == lfm_pkg::ADDR_MASK_CFG) |=> mask_reg == $past(i_reg_wdata))
        else $error("mask write not applied");
    a_read_mask: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_reg_re && i_reg_addr == lfm_pkg::ADDR_MASK_CFG) |=> o_reg_rdata == $past(mask_reg))
        else $error("mask readback wrong");
    a_read_short: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_reg_re && i_reg_addr == lfm_pkg::ADDR_SHORT_STAT)
        |=> o_reg_rdata == {1'b0, $past(short_reg)})
        else $error("short status readback wrong");
    a_read_trace: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_reg_re && i_reg_addr == lfm_pkg::ADDR_TRACE_STAT)
        |=> o_reg_rdata == {1'b0, $past(trace_reg)})
        else $error("open trace readback wrong");
    a_read_open: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_reg_re && i_reg_addr == lfm_pkg::ADDR_OPEN_STAT)
        |=> o_reg_rdata == {1'b0, $past(open_reg)})
        else $error("open status readback wrong");
    a_read_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_reg_re |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");
endmodule // lfm_monitor

/* tb/lfm_host.sv */
// host side register access model
`timescale 1ns/1ps
module lfm_host (
    input wire logic i_mclk,
    input wire logic [lfm_pkg::REG_W-1:0] i_rdata,
    output logic [7:0] o_addr,
    output logic [lfm_pkg::REG_W-1:0] o_wdata,
    output logic o_we,
    output logic o_re
);
    initial begin
        o_addr = 8'h00;
        o_wdata = 13'h0000;
        o_we = 1'b0;
        o_re = 1'b0;
    end
    // released data shows the inverse, not a stale copy
    task automatic wr(input logic [7:0] a, input logic [12:0] d);
        @(posedge i_mclk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_we = 1'b1;
        @(posedge i_mclk);
        #1;
        o_we = 1'b0;
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [12:0] d);
        @(posedge i_mclk);
        #1;
        o_addr = a;
        o_re = 1'b1;
        @(posedge i_mclk);
        #1;
        o_re = 1'b0;
        d = i_rdata;
    endtask
endmodule // lfm_host

/* tb/tb_lfm_monitor.sv */
// self-checking bench for the led fault monitor
`timescale 1ns/1ps
module tb_lfm_monitor;
    typedef struct {int sw; logic sc, lc; logic [11:0] du, th; logic es, et;} lfm_row_t;
    logic i_mclk, i_rst_n, i_serial_err, we, re, o_fault_n;
    lfm_pkg::lfm_sense_t sense;
    lfm_pkg::lfm_duty_t duty;
    logic [11:0] sw_open, o_sw_open, es, et;
    logic [7:0] addr;
    logic [12:0] wdata, rdata, d;
    int error_cnt = 0;
    int n_checks = 0;
    lfm_row_t rows[5] = '{'{0, 1, 0, 12'h064, 12'h000, 1, 0}, '{1, 1, 0, 12'h005, 12'h006, 0, 0},
        '{2, 1, 0, 12'h006, 12'h006, 1, 0}, '{11, 0, 1, 12'h064, 12'h006, 0, 1},
        '{3, 0, 0, 12'h064, 12'h006, 0, 0}};
    lfm_monitor u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sense(sense), .i_sw_open(sw_open),
        .i_duty(duty), .i_serial_err(i_serial_err), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_we(we), .i_reg_re(re), .o_reg_rdata(rdata), .o_sw_open(o_sw_open),
        .o_fault_n(o_fault_n));
    lfm_host u_host (.i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_we(we), .o_re(re));
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #500us;
        error_cnt++;
        conclude();
    end
    initial begin
        i_rst_n = 1'b0;
        i_serial_err = 1'b0;
        sense = '0;
        duty = '0;
        sw_open = 12'h000;
        es = 12'h000;
        et = 12'h000;
        idle(8);
        i_rst_n = 1'b1;
        chk(o_fault_n, 1'b1);
        chk(o_sw_open, 12'h000);
        u_host.rd(8'h0C, d);
        chk(d, 13'h0000);
        u_host.rd(8'h16, d);
        chk(d, 13'h0000);
        $display("reset test done");
        foreach (rows[k]) begin
            u_host.wr(8'h16, {1'b0, rows[k].th});
            duty[rows[k].sw] = rows[k].du;
            sense.short_cmp[rows[k].sw] = rows[k].sc;
            sense.low_cur[rows[k].sw] = rows[k].lc;
            idle(4);
            sw_open[rows[k].sw] = 1'b1;
            idle(4);
            sw_open[rows[k].sw] = 1'b0;
            idle(4);
            sense = '0;
            es[rows[k].sw] = rows[k].es;
            et[rows[k].sw] = rows[k].et;
            u_host.rd(8'h12, d);
            chk(d, {1'b0, es});
            u_host.rd(8'h14, d);
            chk(d, {1'b0, et});
            $display("row %0d done", k);
        end
        chk(o_fault_n, 1'b0);
        u_host.wr(8'h0C, 13'h0007);
        idle(3);
        chk(o_fault_n, 1'b1);
        sense.open_cmp[5] = 1'b1;
        sw_open[5] = 1'b1;
        idle(6);
        chk(o_sw_open[5], 1'b0);
        u_host.rd(8'h13, d);
        chk(d, 13'h0020);
        sense = '0;
        sw_open = 12'hA0A;
        idle(4);
        chk(o_sw_open, 12'hA0A);
        $display("fault pin test done");
        sense.warn_hot = 1'b1;
        idle(6);
        chk(o_fault_n, 1'b0);
        chk(o_sw_open, 12'hA0A);
        u_host.wr(8'h10, 13'h0001);
        u_host.rd(8'h10, d);
        chk(d, 13'h0001);
        sense.warn_hot = 1'b0;
        idle(6);
        chk(o_fault_n, 1'b0);
        u_host.wr(8'h10, 13'h0001);
        u_host.rd(8'h10, d);
        chk(d, 13'h0000);
        idle(2);
        chk(o_fault_n, 1'b1);
        u_host.wr(8'h0C, 13'h000F);
        sense.warn_hot = 1'b1;
        sense.shdn_hot = 1'b1;
        idle(6);
        chk(o_sw_open, 12'h000);
        u_host.rd(8'h10, d);
        chk(d, 13'h0003);
        sense = '0;
        idle(6);
        chk(o_sw_open, 12'hA0A);
        u_host.wr(8'h10, 13'h0001);
        idle(2);
        chk(o_fault_n, 1'b0);
        u_host.wr(8'h10, 13'h0003);
        idle(2);
        chk(o_fault_n, 1'b1);
        u_host.wr(8'h0C, 13'h0007);
        sense.shdn_hot = 1'b1;
        idle(6);
        chk(o_sw_open, 12'hFFF);
        sense = '0;
        idle(6);
        u_host.wr(8'h10, 13'h0003);
        $display("thermal test done");
        i_serial_err = 1'b1;
        sense.grade_err = 1'b1;
        idle(4);
        chk(o_fault_n, 1'b0);
        u_host.rd(8'h10, d);
        chk(d, 13'h000C);
        i_serial_err = 1'b0;
        sense = '0;
        u_host.wr(8'h12, 13'h1FFF);
        u_host.rd(8'h12, d);
        chk(d, {1'b0, es});
        u_host.rd(8'h20, d);
        chk(d, 13'h0000);
        u_host.wr(8'h16, 13'h0007);
        u_host.wr(8'h16, 13'h0006);
        u_host.rd(8'h16, d);
        chk(d, 13'h0006);
        $display("register test done");
        i_rst_n = 1'b0;
        idle(2);
        i_rst_n = 1'b1;
        u_host.rd(8'h13, d);
        chk(d, 13'h0000);
        chk(o_fault_n, 1'b1);
        chk(o_sw_open, 12'hA0A);
        $display("mid-run reset test done");
        conclude();
    end
endmodule // tb_lfm_monitor
